/* src/conv_ctrl_pkg.sv */
/*
  Constants, types and register map for the conversion clock and
  sample control block. Assumes every consumer refers to items by
  their full package-scoped name.
*/
package conv_ctrl_pkg;

  localparam int NUM_PAIRS = 4;
  localparam int CNT_W     = 5;

  // Register byte offsets.
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] STATE_OFS  = 8'h0C;

  // Configuration word fields.
  localparam int CLK_SEL_BIT   = 29;
  localparam int LATCH_OFF_BIT = 26;
  localparam int VREF_3V_BIT   = 13;
  localparam int SPAN_LSB      = 20;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

  // Status and mask layout: per-pair done, busy fall, refused start.
  localparam int DONE_LSB    = 0;
  localparam int BUSY_FALL   = 4;
  localparam int REFUSED_LSB = 8;
  localparam int EVT_W       = 12;
  localparam logic [EVT_W-1:0] EVT_RST = 12'h000;

  // Conversion lengths in conversion-clock ticks.
  localparam logic [CNT_W-1:0] CONV_TICKS  = 5'h13;
  localparam logic [CNT_W-1:0] SLEEP_TICKS = 5'h1A;
  localparam logic [CNT_W-1:0] PRECHG_TICKS = 5'h02;

  // Internal conversion clock period, and its length in pclk cycles.
  localparam int PCLK_PS     = 5000;
  localparam int INT_CLK_PS  = 85000;
  localparam int INT_DIV_DEF = (INT_CLK_PS + PCLK_PS - 1) / PCLK_PS;

  typedef enum logic [1:0] {
    PAIR_IDLE = 2'b00,
    PAIR_ARM  = 2'b01,
    PAIR_PRE  = 2'b11,
    PAIR_CONV = 2'b10
  } pair_state_t;

  typedef struct packed {
    logic active;
    logic precharge;
    logic done;
  } pair_stat_t;

endpackage

/* src/pair_sequencer.sv */
/*
  Per-pair conversion sequencer: holds the pair on a start pulse,
  waits for the next conversion tick, pre-charges and counts ticks.
  Assumes start and tick are single pclk pulses on the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_sequencer (
  // Clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // Control
  input  wire logic                                  start,
  input  wire logic                                  tick,
  input  wire logic [conv_ctrl_pkg::CNT_W-1:0]       ticks_total,
  // Status
  output conv_ctrl_pkg::pair_stat_t                  stat,
  output logic [conv_ctrl_pkg::CNT_W-1:0]            count
);
  conv_ctrl_pkg::pair_state_t     state_q, state_d;
  logic [conv_ctrl_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic                            done_q, done_d;

  wire last = (cnt_q == ticks_total);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    case (state_q)
      conv_ctrl_pkg::PAIR_IDLE: begin
        if (start) begin
          state_d = conv_ctrl_pkg::PAIR_ARM;
        end
      end
      conv_ctrl_pkg::PAIR_ARM: begin
        if (tick) begin
          state_d = conv_ctrl_pkg::PAIR_PRE;
          cnt_d   = 5'h01;
        end
      end
      conv_ctrl_pkg::PAIR_PRE: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == conv_ctrl_pkg::PRECHG_TICKS) begin
            state_d = conv_ctrl_pkg::PAIR_CONV;
          end
        end
      end
      default: begin
        if (tick) begin
          if (last) begin
            state_d = conv_ctrl_pkg::PAIR_IDLE;
            cnt_d   = 5'h00;
            done_d  = 1'b1;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= conv_ctrl_pkg::PAIR_IDLE;
      cnt_q   <= 5'h00;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
    end
  end

  assign stat = '{active:    (state_q != conv_ctrl_pkg::PAIR_IDLE),
                  precharge: (state_q == conv_ctrl_pkg::PAIR_PRE),
                  done:      done_q};
  assign count          = cnt_q;
endmodule
`default_nettype wire

/* src/conv_sample_ctrl.sv */
/*
  Conversion clock and sample control with an APB register slave.
  Picks the conversion clock, sequences four channel pairs, drives
  busy, span and reference selects, and raises a level interrupt.
  Assumes all pins are asynchronous to pclk and the external
  conversion clock is far slower than pclk.
*/
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module conv_sample_ctrl #(
  parameter int INT_DIV = conv_ctrl_pkg::INT_DIV_DEF
) (
  // Clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [7:0]                          paddr,
  input  wire logic [31:0]                         pwdata,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Device pins
  input  wire logic [conv_ctrl_pkg::NUM_PAIRS-1:0] pair_sample_start,
  input  wire logic                                external_conv_clock,
  input  wire logic                                auto_sleep_pin,
  input  wire logic                                range_pin,
  input  wire logic                                sw_mode_pin,
  // Conversion status
  output logic                                     busy,
  output logic [conv_ctrl_pkg::NUM_PAIRS-1:0]      pair_hold,
  output logic [conv_ctrl_pkg::NUM_PAIRS-1:0]      pair_precharge,
  output logic                                     internal_conv_clock,
  // Analog selects
  output logic [conv_ctrl_pkg::NUM_PAIRS-1:0]      span_2x_sel,
  output logic                                     vref_3v_sel,
  // Interrupt
  output logic                                     irq
);
  localparam int NP = conv_ctrl_pkg::NUM_PAIRS;
  localparam int EW = conv_ctrl_pkg::EVT_W;
  localparam int DW = $clog2(INT_DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(INT_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(INT_DIV / 2);
  localparam logic [EW-1:0] EVT_ZERO = conv_ctrl_pkg::EVT_RST;

  // Status and mask are narrower than the bus; both read back through
  // this so that the unused upper bits always return zero.
  function automatic logic [31:0] widen_evt(input logic [EW-1:0] v);
    widen_evt = {{(32 - EW){1'b0}}, v};
  endfunction

  // Pin synchronisers; stage one feeds only stage two.
  logic [NP-1:0] start_s1_q, start_s2_q, start_s3_q;
  logic          external_conv_clock_s1_q, external_conv_clock_s2_q, external_conv_clock_s3_q;
  logic          sleep_s1_q, sleep_s2_q;
  logic          range_s1_q, range_s2_q;
  logic          swm_s1_q, swm_s2_q;

  // Conversion clock generation.
  logic [DW-1:0] div_q, div_d;
  logic          int_tick;
  logic          ext_tick;
  logic          use_ext;
  logic          conv_tick;

  // Pair sequencing.
  conv_ctrl_pkg::pair_stat_t stat [NP];
  logic [NP-1:0] start_edge;
  logic [NP-1:0] pair_active;
  logic [NP-1:0] pair_done;
  logic [NP-1:0] start_ok;
  logic [NP-1:0] start_bad;
  logic [conv_ctrl_pkg::CNT_W-1:0] ticks_total;
  logic          busy_q, busy_d;
  logic          busy_fall;

  // Span and reference.
  logic          range_lat_q, range_lat_d;
  logic [NP-1:0] span_q, span_d;
  logic          vref_q;

  // Registers.
  logic [31:0]   config_q, config_d;
  logic [EW-1:0] status_q, status_d;
  logic [EW-1:0] mask_q, mask_d;
  logic [EW-1:0] events;
  logic [31:0]   rdata_q, rdata_d;
  logic          err_q, err_d;
  logic          irq_q;
  logic [31:0]   state_word;

  // APB decode.
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire rd      = access & ~pwrite;
  wire hit_cfg = (paddr == conv_ctrl_pkg::CONFIG_OFS);
  wire hit_sts = (paddr == conv_ctrl_pkg::STATUS_OFS);
  wire hit_msk = (paddr == conv_ctrl_pkg::MASK_OFS);
  wire hit_st  = (paddr == conv_ctrl_pkg::STATE_OFS);
  wire mapped  = hit_cfg | hit_sts | hit_msk | hit_st;

  wire sw_mode = swm_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_s1_q <= '0;
      start_s2_q <= '0;
      start_s3_q <= '0;
    end else begin
      start_s1_q <= pair_sample_start;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
    end
  end

  // The external clock gets a third stage so that its rising edge is
  // found without ever reading the first, possibly metastable, stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_conv_clock_s1_q <= 1'b0;
      external_conv_clock_s2_q <= 1'b0;
      external_conv_clock_s3_q <= 1'b0;
    end else begin
      external_conv_clock_s1_q <= external_conv_clock;
      external_conv_clock_s2_q <= external_conv_clock_s1_q;
      external_conv_clock_s3_q <= external_conv_clock_s2_q;
    end
  end

  // Level pins need only the two stages.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      sleep_s1_q <= auto_sleep_pin;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_s1_q <= 1'b0;
      range_s2_q <= 1'b0;
    end else begin
      range_s1_q <= range_pin;
      range_s2_q <= range_s1_q;
    end
  end

  // A change of mode takes effect two cycles late, so the host should
  // switch modes only while no conversion runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swm_s1_q <= 1'b0;
      swm_s2_q <= 1'b0;
    end else begin
      swm_s1_q <= sw_mode_pin;
      swm_s2_q <= swm_s1_q;
    end
  end

  // Internal clock is free running so a start may land anywhere in
  // its period, which is where the one-tick spread comes from.
  assign div_d    = (div_q == DIV_LAST) ? '0 : div_q + DW'(1);
  assign int_tick = (div_q == DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // Only rising edges count, so a clock parked low is harmless.
  assign ext_tick  = external_conv_clock_s2_q & ~external_conv_clock_s3_q;
  assign use_ext   = sw_mode & config_q[conv_ctrl_pkg::CLK_SEL_BIT];
  assign conv_tick = use_ext ? ext_tick : int_tick;

  assign ticks_total = sleep_s2_q ? conv_ctrl_pkg::SLEEP_TICKS
                                  : conv_ctrl_pkg::CONV_TICKS;

  // A start on a pair that is still converting is refused.
  assign start_edge = start_s2_q & ~start_s3_q;
  assign start_ok   = start_edge & ~pair_active;
  assign start_bad  = start_edge & pair_active;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pair
      pair_sequencer u_seq (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (start_ok[g]),
        .tick        (conv_tick),
        .ticks_total (ticks_total),
        .stat        (stat[g]),
        .count       ()
      );
      assign pair_active[g]    = stat[g].active;
      assign pair_done[g]      = stat[g].done;
      assign pair_precharge[g] = stat[g].precharge;
    end
  endgenerate

  // Busy covers the start pulse cycle and every active pair.
  assign busy_d    = (|start_edge) | (|pair_active);
  assign busy_fall = busy_q & ~busy_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // The span pin is sampled only as busy drops, so it cannot change
  // the range under a running conversion.
  assign range_lat_d =
    (busy_fall & ~sw_mode & ~config_q[conv_ctrl_pkg::LATCH_OFF_BIT])
    ? range_s2_q : range_lat_q;

  assign span_d = sw_mode
    ? config_q[conv_ctrl_pkg::SPAN_LSB +: NP]
    : {NP{range_lat_q}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_lat_q <= 1'b0;
      span_q      <= '0;
    end else begin
      range_lat_q <= range_lat_d;
      span_q      <= span_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_q <= 1'b0;
    end else begin
      vref_q <= config_q[conv_ctrl_pkg::VREF_3V_BIT];
    end
  end

  // Register writes land on the access edge only; an unmapped address
  // writes nothing.
  assign config_d = (wr & hit_cfg) ? pwdata : config_q;
  assign mask_d   = (wr & hit_msk) ? pwdata[EW-1:0] : mask_q;

  // Events set status bits; a set in the clearing read cycle wins.
  wire clr_sts = rd & hit_sts;
  assign events = {start_bad, 3'h0, busy_fall, pair_done};
  assign status_d = (clr_sts ? EVT_ZERO : status_q) | events;

  // Live state word; bit 0 is spare and reads as zero.
  assign state_word = {18'h00000, use_ext, sleep_s2_q, sw_mode, range_lat_q,
                       span_q, pair_active, busy_q, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= conv_ctrl_pkg::CONFIG_RST;
    end else begin
      config_q <= config_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= conv_ctrl_pkg::EVT_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= conv_ctrl_pkg::EVT_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Read data is captured in the setup cycle so that it leaves a
  // flip-flop; the read-clear still lands on the access edge. Status is
  // taken from its next value, so an event that lands on the setup edge
  // is reported by this read instead of being lost to its clear.
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d = ~mapped;
      if (hit_cfg) begin
        rdata_d = config_q;
      end else if (hit_sts) begin
        rdata_d = widen_evt(status_d);
      end else if (hit_msk) begin
        rdata_d = widen_evt(mask_q);
      end else if (hit_st) begin
        rdata_d = state_word;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // The interrupt follows the next status, so it drops on the same edge
  // as the clearing read and never lingers for a cycle.
  wire irq_d = |(status_d & mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Zero wait states: every access phase completes in its first cycle.

  assign prdata              = rdata_q;
  assign pready              = access;
  assign pslverr             = access & err_q;
  assign busy                = busy_q;
  assign pair_hold           = pair_active;
  assign internal_conv_clock = (div_q < DIV_HALF);
  assign span_2x_sel         = span_q;
  assign vref_3v_sel         = vref_q;
  assign irq                 = irq_q;
endmodule
`default_nettype wire

/* tb/conv_props.sv */
/*
  Assertion checker for conv_sample_ctrl, watching its ports only.
  Assumes a bind from the bench top and INT_DIV of at least 4.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_props #(
  parameter int INT_DIV = 4
) (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Pins and status
  input wire logic [3:0]  pair_sample_start,
  input wire logic        sw_mode_pin,
  input wire logic        busy,
  input wire logic [3:0]  pair_hold,
  input wire logic [3:0]  pair_precharge,
  input wire logic [3:0]  span_2x_sel,
  input wire logic        vref_3v_sel
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_hold_busy;
    (pair_hold != 4'h0) |-> busy;
  endproperty
  a_hold_busy: assert property (p_hold_busy)
    else $error("busy low while a pair converts");
  property p_busy_end;
    $fell(busy) |-> (pair_hold == 4'h0);
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy fell with a pair active");
  property p_busy_drop;
    $fell(|pair_hold) |-> ##[0:2] !busy;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy stayed high after the last pair");
  property p_start_hold;
    $rose(pair_sample_start[0]) && !busy |-> ##[2:6] pair_hold[0];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start edge did not hold the pair");
  property p_pre_in_hold;
    (pair_precharge & ~pair_hold) == 4'h0;
  endproperty
  a_pre_in_hold: assert property (p_pre_in_hold)
    else $error("pre-charge outside a conversion");
  // Eight cycles is two ticks at the smallest divider the bench uses.
  property p_pre_len;
    $rose(pair_precharge[0]) |-> pair_precharge[0] [*8];
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("pre-charge too short");
  property p_vref;
    psel && penable && pwrite && (paddr == conv_ctrl_pkg::CONFIG_OFS)
      |-> ##2 (vref_3v_sel == $past(pwdata[conv_ctrl_pkg::VREF_3V_BIT], 2));
  endproperty
  a_vref: assert property (p_vref)
    else $error("reference select differs from written bit");
  property p_span_hw;
    !sw_mode_pin && $stable(sw_mode_pin) && busy && $past(busy)
      |-> $stable(span_2x_sel);
  endproperty
  a_span_hw: assert property (p_span_hw)
    else $error("span moved during a conversion");
endmodule
`default_nettype wire

/* tb/host_model.sv */
/*
  Host model: drives the per-pair start pins and the external clock.
  Assumes the bench calls start() right after a pclk rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and status
  input  wire logic       pclk,
  input  wire logic       busy,
  input  wire logic       ext_mode,
  // Pins into the device
  output logic [3:0]      pair_sample_start,
  output logic            external_conv_clock
);
  logic [1:0] div_q;
  logic       go;
  initial begin
    pair_sample_start = 4'h0;
    external_conv_clock = 1'b0;
    div_q = 2'h0;
    go = 1'b0;
  end
  // The clock idles low between conversions, so a design that needs a
  // free-running clock shows up as a wrong tick count.
  always @(posedge pclk) begin
    if (ext_mode && (go || busy)) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        external_conv_clock <= ~external_conv_clock;
      end
    end else begin
      div_q <= 2'h0;
      external_conv_clock <= 1'b0;
    end
  end
  task start(input logic [3:0] m);
    repeat (4) @(posedge pclk);
    go <= ext_mode;
    if (ext_mode) begin
      do @(posedge pclk);
      while (!(external_conv_clock && div_q == 2'h1));
    end
    pair_sample_start <= m;
    repeat (6) @(posedge pclk);
    pair_sample_start <= 4'h0;
    go <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Bench for conv_sample_ctrl: APB master task, host model on the pins
  and one task per scenario. Assumes INT_DIV is set to 4 here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pair_sample_start, pair_hold, pair_precharge, span_2x_sel;
  logic        external_conv_clock, auto_sleep_pin, range_pin, sw_mode_pin;
  logic        ext_mode, busy, internal_conv_clock, vref_3v_sel, irq;
  logic        ic_d, xc_d;
  int          errors, tests_run, n_int, n_ext, k;
  conv_sample_ctrl #(.INT_DIV(DIV)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pair_sample_start, .external_conv_clock,
    .auto_sleep_pin, .range_pin, .sw_mode_pin, .busy, .pair_hold,
    .pair_precharge, .internal_conv_clock, .span_2x_sel, .vref_3v_sel,
    .irq
  );
  host_model host (
    .pclk, .busy, .ext_mode, .pair_sample_start, .external_conv_clock
  );
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Rises of the clocks themselves are counted, whatever the sampling.
  always @(posedge pclk) begin
    ic_d <= internal_conv_clock;
    xc_d <= external_conv_clock;
    if (pair_hold[0] && internal_conv_clock && !ic_d) n_int++;
    if (pair_hold[0] && external_conv_clock && !xc_d) n_ext++;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(32'(pready), 32'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_idle;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(busy), 32'h0);
    repeat (DIV) @(posedge pclk);
  endtask
  task conv(input logic [3:0] m);
    n_int = 0;
    n_ext = 0;
    host.start(m);
    chk(32'(busy), 32'h1);
    wait_idle;
  endtask
  task t_regs;
    apb(1'b0, conv_ctrl_pkg::CONFIG_OFS, 32'h0);
    chk(rd, conv_ctrl_pkg::CONFIG_RST);
    apb(1'b1, conv_ctrl_pkg::CONFIG_OFS, 32'h0000_2000);
    apb(1'b0, conv_ctrl_pkg::CONFIG_OFS, 32'h0);
    chk(rd, 32'h0000_2000);
    chk(32'(vref_3v_sel), 32'h1);
    apb(1'b1, conv_ctrl_pkg::CONFIG_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({se, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, conv_ctrl_pkg::STATE_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
  endtask
  task t_int;
    conv(4'h1);
    chk(32'(n_int inside {32'h13, 32'h14}), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, conv_ctrl_pkg::MASK_OFS, 32'h0000_0011);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b0, conv_ctrl_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0011);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("test internal clock done");
  endtask
  task t_sleep;
    auto_sleep_pin <= 1'b1;
    conv(4'h1);
    chk(32'(n_int inside {32'h1A, 32'h1B}), 32'h1);
    auto_sleep_pin <= 1'b0;
    apb(1'b0, conv_ctrl_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0011);
    $display("test auto sleep done");
  endtask
  task t_pairs;
    host.start(4'h2);
    repeat (20) @(posedge pclk);
    host.start(4'h8);
    host.start(4'h2);
    k = 0;
    while (pair_hold[1] !== 1'b0 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(pair_hold[1]), 32'h0);
    chk(32'(busy), 32'h1);
    wait_idle;
    apb(1'b0, conv_ctrl_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_021A);
    $display("test pairs done");
  endtask
  task t_span;
    range_pin <= 1'b1;
    conv(4'h1);
    chk(32'(span_2x_sel), 32'hF);
    range_pin <= 1'b0;
    apb(1'b1, conv_ctrl_pkg::CONFIG_OFS, 32'h0400_0000);
    conv(4'h1);
    chk(32'(span_2x_sel), 32'hF);
    sw_mode_pin <= 1'b1;
    apb(1'b1, conv_ctrl_pkg::CONFIG_OFS, 32'h0050_0000);
    repeat (4) @(posedge pclk);
    chk(32'(span_2x_sel), 32'h5);
    $display("test span done");
  endtask
  task t_ext;
    apb(1'b1, conv_ctrl_pkg::CONFIG_OFS, 32'h2000_0000);
    ext_mode <= 1'b1;
    apb(1'b0, conv_ctrl_pkg::STATE_OFS, 32'h0);
    chk(32'(rd[13]), 32'h1);
    conv(4'h1);
    // Nineteen whole cycles are bounded by twenty rising edges.
    chk(32'(n_ext - 1), 32'h13);
    sw_mode_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, conv_ctrl_pkg::STATE_OFS, 32'h0);
    chk(32'(rd[13]), 32'h0);
    $display("test external clock done");
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {auto_sleep_pin, range_pin, sw_mode_pin, ext_mode} = 4'h0;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_int;
    t_sleep;
    t_pairs;
    t_span;
    t_ext;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run;
  end
endmodule
bind conv_sample_ctrl conv_props #(.INT_DIV(INT_DIV)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pair_sample_start, .sw_mode_pin, .busy, .pair_hold, .pair_precharge,
  .span_2x_sel, .vref_3v_sel
);
`default_nettype wire
